// ### logic/tc_defs.svh
`ifndef TC_DEFS_SVH
`define TC_DEFS_SVH

// register byte offsets
`define TC_CTRL_OFS     8'h00
`define TC_ACTEN_OFS    8'h04
`define TC_VBASE_OFS    8'h08
`define TC_STAT_OFS     8'h0C
`define TC_MASK_OFS     8'h10
`define TC_STATE_OFS    8'h14

// controller_control_register fields
`define TC_BURST_BIT    11
`define TC_SHORT_BIT    10
`define TC_RCHAIN_BIT   4

// reset values
`define TC_CTRL_RST     32'h0000_0000
`define TC_ACTEN_RST    32'h0000_0000
`define TC_VBASE_RST    32'h0000_0000
`define TC_STAT_RST     3'h0
`define TC_MASK_RST     3'h0

// status / mask bits
`define TC_ST_CPUINT    0
`define TC_ST_DISABLE   1
`define TC_ST_CHAIN     2

// mode_word_a fields
`define TC_MD_HI        7
`define TC_MD_LO        6
`define TC_SZ_HI        5
`define TC_SZ_LO        4
`define TC_SM_BIT       3
`define TC_MODE_REPEAT  2'h1

// mode_word_b fields
`define TC_CHAIN_ENABLE_BIT     7
`define TC_CHAIN_ON_COUNT_ZERO_SELECT_BIT     6
`define TC_PER_TRANSFER_INTERRUPT_SELECT_BIT    5
`define TC_DM_BIT       3

// descriptor geometry
`define TC_NORMAL_WORDS 2'h3
`define TC_SHORT_WORDS  2'h2
`define TC_UPPER_ONES   8'hFF

// bus answers
`define TC_RESP_OKAY    2'h0
`define TC_RESP_SLVERR  2'h2

`endif

// ### logic/tc_pkg.sv
package tc_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_GRANT,
		ST_VEC,
		ST_FETCH,
		ST_READ,
		ST_WRITE,
		ST_BACK,
		ST_DONE
	} tc_state_t;

	typedef struct packed {
		logic [7:0]  mode_word_a;
		logic [7:0]  mode_word_b;
		logic [31:0] source_address_reg;
		logic [31:0] destination_address_reg;
		logic [15:0] transfer_count_a;
		logic [15:0] block_count_b;
	} tc_desc_t;
endpackage

// ### logic/tc_mem_if.sv
`timescale 1ns/1ps
interface tc_mem_if;
	logic        start;
	logic        we;
	logic [1:0]  size;
	logic [31:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic        done;

	modport fsm (output start, we, size, addr, wdata, input rdata, done);
	modport mst (input start, we, size, addr, wdata, output rdata, done);
endinterface

// ### logic/tc_bus_master.sv
`timescale 1ns/1ps
module tc_bus_master (
	input  wire logic        mclk_i,
	input  wire logic        reset_i,
	tc_mem_if.mst            op,
	output logic             mem_req_o,
	output logic             mem_we_o,
	output logic [1:0]       mem_size_o,
	output logic [31:0]      mem_addr_o,
	output logic [31:0]      mem_wdata_o,
	input  wire logic [31:0] mem_rdata_i,
	input  wire logic        mem_ack_i
);
	logic        done;
	logic [31:0] rdata;
	wire         take = op.start & ~mem_req_o;
	wire         fin  = mem_req_o & mem_ack_i;

	assign op.done  = done;
	assign op.rdata = rdata;

	// one access at a time, held until acknowledged
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			mem_req_o   <= 1'b0;
			mem_we_o    <= 1'b0;
			mem_size_o  <= 2'h0;
			mem_addr_o  <= 32'h0000_0000;
			mem_wdata_o <= 32'h0000_0000;
			done        <= 1'b0;
			rdata       <= 32'h0000_0000;
		end else begin
			done <= fin;
			if (take) begin
				mem_req_o   <= 1'b1;
				mem_we_o    <= op.we;
				mem_size_o  <= op.size;
				mem_addr_o  <= op.addr;
				mem_wdata_o <= op.wdata;
			end else if (fin) begin
				mem_req_o <= 1'b0;
				rdata     <= mem_rdata_i;
			end
		end
	end
endmodule

// ### logic/tc_chain_ctrl.sv
// Notes on behaviour
// - a descriptor with chain_enable set makes one activation run several descriptors back to back.
// - with chain_enable and chain_on_count_zero_select set, chaining waits for the count to reach 0.
// - a chained descriptor raises no cpu interrupt and touches neither source flag nor activation enable.
// - in repeat mode with repeat_chain_enable, chaining follows the transfer made at count 1.
// - every chained descriptor holds its own addresses, counts and mode words, used on their own.
// - burst_hold_bus at 0 (bit 11, reset 0) releases the bus after each activation source.
// - burst_hold_bus at 1 keeps the bus while requests are pending and releases after the last.
// - short_address_mode at 0 (bit 10) fetches a descriptor as 4 longwords, normal layout.
// - short_address_mode at 1 fetches a descriptor as 3 longwords, compact layout.
// - short_address_mode forces the top 8 address bits to ones; software uses it for peripheral-ram only.
`timescale 1ns/1ps
`include "tc_defs.svh"
module tc_chain_ctrl #(
	parameter int NSRC = 8
) (
	input  wire logic            mclk_i,
	input  wire logic            reset_i,
	input  wire logic [7:0]      s_axi_awaddr_i,
	input  wire logic            s_axi_awvalid_i,
	output logic                 s_axi_awready_o,
	input  wire logic [31:0]     s_axi_wdata_i,
	input  wire logic [3:0]      s_axi_wstrb_i,
	input  wire logic            s_axi_wvalid_i,
	output logic                 s_axi_wready_o,
	output logic [1:0]           s_axi_bresp_o,
	output logic                 s_axi_bvalid_o,
	input  wire logic            s_axi_bready_i,
	input  wire logic [7:0]      s_axi_araddr_i,
	input  wire logic            s_axi_arvalid_i,
	output logic                 s_axi_arready_o,
	output logic [31:0]          s_axi_rdata_o,
	output logic [1:0]           s_axi_rresp_o,
	output logic                 s_axi_rvalid_o,
	input  wire logic            s_axi_rready_i,
	input  wire logic [NSRC-1:0] act_req_i,
	output logic                 bus_req_o,
	input  wire logic            bus_gnt_i,
	output logic                 mem_req_o,
	output logic                 mem_we_o,
	output logic [1:0]           mem_size_o,
	output logic [31:0]          mem_addr_o,
	output logic [31:0]          mem_wdata_o,
	input  wire logic [31:0]     mem_rdata_i,
	input  wire logic            mem_ack_i,
	output logic                 cpu_irq_o,
	output logic                 src_clr_o,
	output logic [7:0]           evt_src_o,
	output logic                 irq_o
);
	localparam int SW = $clog2(NSRC);

	tc_mem_if op ();

	tc_bus_master u_mst (
		.mclk_i     (mclk_i),
		.reset_i    (reset_i),
		.op         (op),
		.mem_req_o  (mem_req_o),
		.mem_we_o   (mem_we_o),
		.mem_size_o (mem_size_o),
		.mem_addr_o (mem_addr_o),
		.mem_wdata_o(mem_wdata_o),
		.mem_rdata_i(mem_rdata_i),
		.mem_ack_i  (mem_ack_i)
	);

	tc_pkg::tc_state_t state;
	tc_pkg::tc_desc_t  d;
	logic [31:0]       ctrl;
	logic [NSRC-1:0]   acten;
	logic [31:0]       vbase;
	logic [2:0]        stat;
	logic [2:0]        mask;
	logic [NSRC-1:0]   pend;
	logic [SW-1:0]     src;
	logic [31:0]       desc_addr;
	logic [1:0]        widx;
	logic              short_lat;
	logic              acc_wait;
	logic              cnt_hit;
	logic [31:0]       data_buf;
	logic [31:0]       sar0;
	logic [31:0]       dar0;
	logic              aw_full;
	logic              w_full;
	logic [7:0]        aw_addr;
	logic [31:0]       w_data;
	logic [3:0]        w_strb;

	// source pick: lowest index pending and enabled
	wire [NSRC-1:0] ready_src = pend & acten;
	wire            any_ready = |ready_src;
	logic [SW-1:0]  pick;
	always_comb begin
		pick = '0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (ready_src[i])
				pick = SW'(i);
		end
	end

	// descriptor view
	wire       chain_enable   = d.mode_word_b[`TC_CHAIN_ENABLE_BIT];
	wire       chain_on_count_zero_select   = d.mode_word_b[`TC_CHAIN_ON_COUNT_ZERO_SELECT_BIT];
	wire       per_transfer_interrupt_select  = d.mode_word_b[`TC_PER_TRANSFER_INTERRUPT_SELECT_BIT];
	wire       rpt    = d.mode_word_a[`TC_MD_HI:`TC_MD_LO] == `TC_MODE_REPEAT;
	wire [1:0] sz     = d.mode_word_a[`TC_SZ_HI:`TC_SZ_LO];
	wire       burst  = ctrl[`TC_BURST_BIT];
	wire       rchain = ctrl[`TC_RCHAIN_BIT];
	wire [1:0] last_w = short_lat ? `TC_SHORT_WORDS : `TC_NORMAL_WORDS;
	wire [31:0] step  = (sz == 2'h0) ? 32'h1 : (sz == 2'h1) ? 32'h2 : 32'h4;
	wire        hit_now = rpt ? (d.transfer_count_a[7:0] == 8'h01) : (d.transfer_count_a == 16'h0001);

	// chain decision once a descriptor finishes
	wire cnt_ok   = cnt_hit & (~rpt | rchain);
	wire chain_go = chain_enable & (~chain_on_count_zero_select | cnt_ok);
	wire end_src  = (state == tc_pkg::ST_DONE) & ~chain_go;
	wire irq_fire = end_src & ~chain_enable & ((cnt_hit & ~rpt) | per_transfer_interrupt_select);
	wire dis_fire = end_src & ~chain_enable & cnt_hit & ~rpt;
	wire clr_fire = end_src & ~chain_enable & ~irq_fire;
	wire hold_bus = burst & any_ready;
	wire take_src = ((state == tc_pkg::ST_IDLE) | (end_src & hold_bus)) & any_ready;

	// descriptor word composition for write back
	function automatic logic [31:0] desc_word(input logic [1:0] k, input logic sh, input tc_pkg::tc_desc_t t);
		logic [31:0] w;
		w = 32'h0000_0000;
		unique case (k)
			2'h0: w = sh ? {t.mode_word_a, t.source_address_reg[23:0]} : {t.mode_word_a, t.mode_word_b, 16'h0000};
			2'h1: w = sh ? {t.mode_word_b, t.destination_address_reg[23:0]} : t.source_address_reg;
			2'h2: w = sh ? {t.transfer_count_a, t.block_count_b} : t.destination_address_reg;
			2'h3: w = {t.transfer_count_a, t.block_count_b};
		endcase
		return w;
	endfunction

	// bus access issue
	wire acc_state = (state == tc_pkg::ST_VEC) | (state == tc_pkg::ST_FETCH) | (state == tc_pkg::ST_READ)
		| (state == tc_pkg::ST_WRITE) | (state == tc_pkg::ST_BACK);
	wire [31:0] slot = desc_addr + {28'h0, widx, 2'h0};
	assign op.start = acc_state & ~acc_wait;
	assign op.we    = (state == tc_pkg::ST_WRITE) | (state == tc_pkg::ST_BACK);
	assign op.size  = ((state == tc_pkg::ST_READ) | (state == tc_pkg::ST_WRITE)) ? sz : 2'h2;
	assign op.addr  = (state == tc_pkg::ST_VEC) ? vbase + {{(30 - SW){1'b0}}, src, 2'h0}
		: (state == tc_pkg::ST_READ) ? d.source_address_reg : (state == tc_pkg::ST_WRITE) ? d.destination_address_reg : slot;
	assign op.wdata = (state == tc_pkg::ST_BACK) ? desc_word(widx, short_lat, d) : data_buf;

	// mastership held from request until the end of service
	assign bus_req_o = state != tc_pkg::ST_IDLE;

	always_ff @(posedge mclk_i) begin
		if (reset_i)
			acc_wait <= 1'b0;
		else if (op.start)
			acc_wait <= 1'b1;
		else if (op.done)
			acc_wait <= 1'b0;
	end

	// sequencer
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			state     <= tc_pkg::ST_IDLE;
			src       <= '0;
			short_lat <= 1'b0;
			desc_addr <= 32'h0000_0000;
			widx      <= 2'h0;
		end else begin
			unique case (state)
				tc_pkg::ST_IDLE: if (any_ready) state <= tc_pkg::ST_GRANT;
				tc_pkg::ST_GRANT: if (bus_gnt_i) state <= tc_pkg::ST_VEC;
				tc_pkg::ST_VEC: if (op.done) begin
					desc_addr <= op.rdata;
					widx      <= 2'h0;
					state     <= tc_pkg::ST_FETCH;
				end
				tc_pkg::ST_FETCH: if (op.done) begin
					widx  <= (widx == last_w) ? 2'h0 : widx + 2'h1;
					state <= (widx == last_w) ? tc_pkg::ST_READ : tc_pkg::ST_FETCH;
				end
				tc_pkg::ST_READ: if (op.done) state <= tc_pkg::ST_WRITE;
				tc_pkg::ST_WRITE: if (op.done) state <= tc_pkg::ST_BACK;
				tc_pkg::ST_BACK: if (op.done) begin
					widx  <= (widx == last_w) ? 2'h0 : widx + 2'h1;
					state <= (widx == last_w) ? tc_pkg::ST_DONE : tc_pkg::ST_BACK;
				end
				tc_pkg::ST_DONE: begin
					if (chain_go) begin
						desc_addr <= desc_addr + {28'h0, last_w, 2'h0} + 32'h4;
						state     <= tc_pkg::ST_FETCH;
					end else if (hold_bus)
						state <= tc_pkg::ST_VEC;
					else
						state <= tc_pkg::ST_IDLE;
				end
			endcase
			if (take_src) begin
				src       <= pick;
				short_lat <= ctrl[`TC_SHORT_BIT];
			end
		end
	end

	// descriptor load and update
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			d        <= '0;
			sar0     <= 32'h0000_0000;
			dar0     <= 32'h0000_0000;
			data_buf <= 32'h0000_0000;
			cnt_hit  <= 1'b0;
		end else if (op.done) begin
			unique case (state)
				tc_pkg::ST_FETCH: begin
					unique case ({short_lat, widx})
						3'h0: {d.mode_word_a, d.mode_word_b} <= op.rdata[31:16];
						3'h1: {d.source_address_reg, sar0} <= {op.rdata, op.rdata};
						3'h2: {d.destination_address_reg, dar0} <= {op.rdata, op.rdata};
						3'h3, 3'h6: {d.transfer_count_a, d.block_count_b} <= op.rdata;
						3'h4: begin
							d.mode_word_a <= op.rdata[31:24];
							d.source_address_reg <= {`TC_UPPER_ONES, op.rdata[23:0]};
							sar0  <= {`TC_UPPER_ONES, op.rdata[23:0]};
						end
						3'h5: begin
							d.mode_word_b <= op.rdata[31:24];
							d.destination_address_reg <= {`TC_UPPER_ONES, op.rdata[23:0]};
							dar0  <= {`TC_UPPER_ONES, op.rdata[23:0]};
						end
						default: data_buf <= data_buf;
					endcase
				end
				tc_pkg::ST_READ: data_buf <= op.rdata;
				tc_pkg::ST_WRITE: begin
					cnt_hit <= hit_now;
					if (rpt & hit_now) begin
						d.transfer_count_a[7:0] <= d.transfer_count_a[15:8];
						d.source_address_reg      <= sar0;
						d.destination_address_reg      <= dar0;
					end else begin
						d.transfer_count_a <= rpt ? {d.transfer_count_a[15:8], d.transfer_count_a[7:0] - 8'h01} : d.transfer_count_a - 16'h0001;
						if (d.mode_word_a[`TC_SM_BIT])
							d.source_address_reg <= d.source_address_reg + step;
						if (d.mode_word_b[`TC_DM_BIT])
							d.destination_address_reg <= d.destination_address_reg + step;
					end
				end
				default: cnt_hit <= cnt_hit;
			endcase
		end
	end

	// activation pending, events to cpu and sources
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			pend      <= '0;
			cpu_irq_o <= 1'b0;
			src_clr_o <= 1'b0;
			evt_src_o <= 8'h00;
		end else begin
			pend      <= (pend & ~(take_src ? NSRC'(1) << pick : '0)) | act_req_i;
			cpu_irq_o <= irq_fire;
			src_clr_o <= clr_fire;
			if (end_src)
				evt_src_o <= 8'(src);
		end
	end

	// register slave: write side
	wire       wr_en  = aw_full & w_full & ~s_axi_bvalid_o;
	wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
	wire [31:0] wval  = w_data & wmask;
	wire       wr_ctl = wr_en & (aw_addr == `TC_CTRL_OFS);
	wire       wr_act = wr_en & (aw_addr == `TC_ACTEN_OFS);
	wire       wr_vb  = wr_en & (aw_addr == `TC_VBASE_OFS);
	wire       wr_st  = wr_en & (aw_addr == `TC_STAT_OFS);
	wire       wr_mk  = wr_en & (aw_addr == `TC_MASK_OFS);
	wire       wr_hit = wr_ctl | wr_act | wr_vb | wr_st | wr_mk | (aw_addr == `TC_STATE_OFS);
	wire [2:0] st_set = {end_src & chain_go ? 1'b0 : (state == tc_pkg::ST_DONE) & chain_go, dis_fire, irq_fire};
	wire [NSRC-1:0] dis_mask = dis_fire ? NSRC'(1) << src : '0;

	assign s_axi_awready_o = ~aw_full;
	assign s_axi_wready_o  = ~w_full;

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			aw_full <= 1'b0;
			w_full  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
		end else begin
			if (s_axi_awvalid_i & ~aw_full) begin
				aw_full <= 1'b1;
				aw_addr <= {s_axi_awaddr_i[7:2], 2'h0};
			end else if (wr_en)
				aw_full <= 1'b0;
			if (s_axi_wvalid_i & ~w_full) begin
				w_full <= 1'b1;
				w_data <= s_axi_wdata_i;
				w_strb <= s_axi_wstrb_i;
			end else if (wr_en)
				w_full <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			ctrl           <= `TC_CTRL_RST;
			acten          <= NSRC'(`TC_ACTEN_RST);
			vbase          <= `TC_VBASE_RST;
			stat           <= `TC_STAT_RST;
			mask           <= `TC_MASK_RST;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= `TC_RESP_OKAY;
		end else begin
			if (wr_ctl)
				ctrl <= (ctrl & ~wmask) | wval;
			acten <= (wr_act ? ((acten & ~wmask[NSRC-1:0]) | wval[NSRC-1:0]) : acten) & ~dis_mask;
			if (wr_vb)
				vbase <= (vbase & ~wmask) | wval;
			if (wr_mk)
				mask <= (mask & ~wmask[2:0]) | wval[2:0];
			stat <= (stat & ~(wr_st ? wval[2:0] : 3'h0)) | st_set;
			if (wr_en) begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= wr_hit ? `TC_RESP_OKAY : `TC_RESP_SLVERR;
			end else if (s_axi_bready_i)
				s_axi_bvalid_o <= 1'b0;
		end
	end

	assign irq_o = |(stat & mask);

	// register slave: read side
	wire [7:0] ra = {s_axi_araddr_i[7:2], 2'h0};
	wire [31:0] busy_word = {16'h0000, 8'(src), 4'h0, short_lat, 3'(state)};
	wire ra_hit = (ra == `TC_CTRL_OFS) | (ra == `TC_ACTEN_OFS) | (ra == `TC_VBASE_OFS)
		| (ra == `TC_STAT_OFS) | (ra == `TC_MASK_OFS) | (ra == `TC_STATE_OFS);
	wire [31:0] rd_word = (ra == `TC_CTRL_OFS) ? ctrl : (ra == `TC_ACTEN_OFS) ? 32'(acten)
		: (ra == `TC_VBASE_OFS) ? vbase : (ra == `TC_STAT_OFS) ? {29'h0, stat}
		: (ra == `TC_MASK_OFS) ? {29'h0, mask} : (ra == `TC_STATE_OFS) ? busy_word : 32'h0000_0000;

	assign s_axi_arready_o = ~s_axi_rvalid_o;

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o  <= 32'h0000_0000;
			s_axi_rresp_o  <= `TC_RESP_OKAY;
		end else if (s_axi_arvalid_i & ~s_axi_rvalid_o) begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o  <= rd_word;
			s_axi_rresp_o  <= ra_hit ? `TC_RESP_OKAY : `TC_RESP_SLVERR;
		end else if (s_axi_rready_i)
			s_axi_rvalid_o <= 1'b0;
	end
endmodule

// ### sim/tc_chain_ctrl_properties.sv
`timescale 1ns/1ps
module tc_chain_ctrl_chk (
	input wire logic        mclk_i,
	input wire logic        reset_i,
	input wire logic        s_axi_arready_o,
	input wire logic [1:0]  s_axi_bresp_o,
	input wire logic        s_axi_bvalid_o,
	input wire logic        s_axi_bready_i,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic        s_axi_rvalid_o,
	input wire logic        s_axi_rready_i,
	input wire logic        bus_req_o,
	input wire logic        mem_req_o,
	input wire logic [31:0] mem_addr_o,
	input wire logic [31:0] mem_wdata_o,
	input wire logic        mem_ack_i,
	input wire logic        cpu_irq_o,
	input wire logic        src_clr_o
);
	default clocking @(posedge mclk_i);
	endclocking
	default disable iff (reset_i);
	property p_mem_hold;
		mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_wdata_o);
	endproperty
	a_mem_hold: assert property (p_mem_hold) else $error("memory request moved");
	property p_ack_drop;
		mem_req_o && mem_ack_i |=> !mem_req_o;
	endproperty
	a_ack_drop: assert property (p_ack_drop) else $error("request kept after ack");
	property p_own_bus;
		mem_req_o |-> bus_req_o;
	endproperty
	a_own_bus: assert property (p_own_bus) else $error("access without bus");
	property p_irq_pulse;
		cpu_irq_o |=> !cpu_irq_o;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("cpu interrupt too long");
	property p_irq_excl;
		cpu_irq_o |-> !src_clr_o;
	endproperty
	a_irq_excl: assert property (p_irq_excl) else $error("interrupt with flag clear");
	property p_clr_pulse;
		src_clr_o |=> !src_clr_o;
	endproperty
	a_clr_pulse: assert property (p_clr_pulse) else $error("flag clear too long");
	property p_b_hold;
		s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_r_hold;
		s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	property p_ar_block;
		s_axi_rvalid_o |-> !s_axi_arready_o;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("read taken while answering");
	c_irq: cover property (cpu_irq_o);
	c_clr: cover property (src_clr_o);
	c_wr: cover property (mem_req_o && mem_ack_i);
endmodule

bind tc_chain_ctrl tc_chain_ctrl_chk u_chk (.*);

// ### sim/tc_mem_model.sv
`timescale 1ns/1ps
module tc_mem_model (
	input  wire logic        mclk_i,
	input  wire logic        reset_i,
	input  wire logic        slow_i,
	input  wire logic        bus_req_i,
	output logic             bus_gnt_o,
	input  wire logic        mem_req_i,
	input  wire logic        mem_we_i,
	input  wire logic [1:0]  mem_size_i,
	input  wire logic [31:0] mem_addr_i,
	input  wire logic [31:0] mem_wdata_i,
	output logic [31:0]      mem_rdata_o,
	output logic             mem_ack_o
);
	logic [31:0] ram [logic [31:0]];
	logic [31:0] wa;
	logic [31:0] w;
	logic [1:0]  lag;
	int          n_rd = 0;
	assign wa = {mem_addr_i[31:2], 2'h0};
	initial begin
		bus_gnt_o = 1'b0;
		mem_ack_o = 1'b0;
		mem_rdata_o = 32'hA5A5_A5A5;
	end
	// read data only valid on the ack cycle, scrambled otherwise
	always @(posedge mclk_i) begin
		bus_gnt_o <= bus_req_i && !reset_i;
		mem_ack_o <= 1'b0;
		mem_rdata_o <= ~mem_rdata_o;
		if (reset_i || !mem_req_i || mem_ack_o) begin
			lag <= slow_i ? 2'h3 : 2'h0;
		end else if (lag != 2'h0) begin
			lag <= lag - 2'h1;
		end else begin
			mem_ack_o <= 1'b1;
			if (mem_we_i) begin
				w = ram.exists(wa) ? ram[wa] : 32'h0;
				for (int b = 0; b < 4; b++)
					if (mem_size_i == 2'h2 || mem_addr_i[1:0] == b[1:0] || (mem_size_i == 2'h1 && mem_addr_i[1] == b[1]))
						w[8*b+:8] = mem_wdata_i[8*b+:8];
				ram[wa] = w;
			end else begin
				mem_rdata_o <= ram.exists(wa) ? ram[wa] : 32'h0;
				n_rd++;
			end
		end
	end
endmodule

// ### sim/tc_chain_ctrl_test.sv
`timescale 1ns/1ps
`include "tc_defs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tc_chain_ctrl_test;
	logic        mclk_i = 1'b0, reset_i = 1'b1, slow = 1'b0, req_q = 1'b0;
	logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00, act_req_i = 8'h00, evt_src_o;
	logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, mem_addr_o, mem_wdata_o, mem_rdata_i, rd;
	logic [3:0]  s_axi_wstrb_i = 4'hF;
	logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
	logic        s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0, bus_gnt_i, mem_ack_i;
	logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, mem_size_o, rsp;
	logic        bus_req_o, mem_req_o, mem_we_o, cpu_irq_o, src_clr_o, irq_o;
	logic [31:0] pat = 32'hC3C3_0000;
	int          err_total = 0, n_tests = 0, n_irq = 0, n_clr = 0, n_rise = 0, cyc = 0;
	tc_chain_ctrl #(.NSRC(8)) dut (.*);
	tc_mem_model mm (.mclk_i(mclk_i), .reset_i(reset_i), .slow_i(slow), .bus_req_i(bus_req_o),
		.bus_gnt_o(bus_gnt_i), .mem_req_i(mem_req_o), .mem_we_i(mem_we_o), .mem_size_i(mem_size_o),
		.mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i), .mem_ack_o(mem_ack_i));
	always #4 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		cyc++;
		if (cpu_irq_o === 1'b1) n_irq++;
		if (src_clr_o === 1'b1) n_clr++;
		if (bus_req_o === 1'b1 && !req_q) n_rise++;
		req_q <= bus_req_o;
		if (cyc == 20000) begin
			err_total++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checks %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		do begin
			@(posedge mclk_i);
			if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
			if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
		end while (!s_axi_bvalid_o);
		s_axi_bready_i <= 1'b1;
		@(posedge mclk_i);
		s_axi_bready_i <= 1'b0;
		`CHK("bresp", er, s_axi_bresp_o)
	endtask
	task automatic rdr(input logic [7:0] a);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		do begin
			@(posedge mclk_i);
			if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
		end while (!s_axi_rvalid_o);
		s_axi_rready_i <= 1'b1;
		@(posedge mclk_i);
		s_axi_rready_i <= 1'b0;
		rd = s_axi_rdata_o;
		rsp = s_axi_rresp_o;
	endtask
	// descriptors, vectors and data all sit in on-chip ram of the model
	task automatic put(input logic [31:0] a, input logic [7:0] ma, mb, input logic [31:0] s, d, input logic [15:0] c);
		mm.ram[a] = {ma, mb, 16'h0000};
		mm.ram[a + 32'h4] = s;
		mm.ram[a + 32'h8] = d;
		mm.ram[a + 32'hC] = {c, 16'h0000};
		mm.ram[s] = s ^ pat;
		mm.ram[d] = 32'h0;
	endtask
	task automatic fire(input logic [7:0] m);
		n_irq = 0;
		n_clr = 0;
		n_rise = 0;
		mm.n_rd = 0;
		act_req_i <= m;
		@(posedge mclk_i);
		act_req_i <= 8'h00;
		repeat (2) begin
			repeat (3) @(posedge mclk_i);
			while (bus_req_o) @(posedge mclk_i);
		end
		repeat (3) @(posedge mclk_i);
	endtask
	task automatic t_regs();
		logic [7:0] ofs [6] = '{`TC_CTRL_OFS, `TC_ACTEN_OFS, `TC_VBASE_OFS, `TC_STAT_OFS, `TC_MASK_OFS, 8'h40};
		for (int i = 0; i < 6; i++) begin
			rdr(ofs[i]);
			`CHK("reset value", 32'h0, rd)
			`CHK("rresp", (i == 5) ? `TC_RESP_SLVERR : `TC_RESP_OKAY, rsp)
		end
		wr(8'h40, 32'hFFFF_FFFF, `TC_RESP_SLVERR);
	endtask
	task automatic t_single();
		mm.ram[32'h100] = 32'h200;
		put(32'h200, 8'h20, 8'h00, 32'h1000, 32'h2000, 16'h0001);
		fire(8'h01);
		`CHK("normal reads", 6, mm.n_rd)
		`CHK("dest", 32'h1000 ^ pat, mm.ram[32'h2000])
		`CHK("irq pulses", 1, n_irq)
		`CHK("no clear", 0, n_clr)
		`CHK("irq", 1'b1, irq_o)
		wr(`TC_MASK_OFS, 32'h0);
		`CHK("masked", 1'b0, irq_o)
		wr(`TC_MASK_OFS, 32'h7);
		rdr(`TC_ACTEN_OFS);
		`CHK("enable cleared", 32'h7E, rd)
		wr(`TC_STAT_OFS, 32'h7);
		`CHK("irq cleared", 1'b0, irq_o)
	endtask
	task automatic t_chain();
		mm.ram[32'h104] = 32'h300;
		put(32'h300, 8'h20, 8'h80, 32'h1100, 32'h2100, 16'h0001);
		put(32'h310, 8'h20, 8'h00, 32'h1200, 32'h2200, 16'h0005);
		slow <= 1'b1;
		fire(8'h02);
		slow <= 1'b0;
		`CHK("chain dest", 32'h1100 ^ pat, mm.ram[32'h2100])
		`CHK("next dest", 32'h1200 ^ pat, mm.ram[32'h2200])
		`CHK("chain reads", 11, mm.n_rd)
		`CHK("chain irq", 0, n_irq)
		`CHK("last clears", 1, n_clr)
		rdr(`TC_ACTEN_OFS);
		`CHK("enable kept", 32'h7E, rd)
		rdr(`TC_STAT_OFS);
		`CHK("status", 32'h4, rd)
		wr(`TC_STAT_OFS, 32'h7);
	endtask
	task automatic t_zero();
		mm.ram[32'h108] = 32'h400;
		put(32'h400, 8'h20, 8'hE0, 32'h1300, 32'h2300, 16'h0002);
		put(32'h410, 8'h20, 8'h00, 32'h1400, 32'h2400, 16'h0005);
		fire(8'h04);
		`CHK("no chain yet", 32'h0, mm.ram[32'h2400])
		`CHK("stop quiet", 0, n_irq + n_clr)
		fire(8'h04);
		`CHK("chain at zero", 32'h1400 ^ pat, mm.ram[32'h2400])
		`CHK("select quiet", 0, n_irq)
	endtask
	task automatic t_rep();
		wr(`TC_CTRL_OFS, 32'h10);
		mm.ram[32'h10C] = 32'h500;
		put(32'h500, 8'h60, 8'hC0, 32'h1500, 32'h2500, 16'h0201);
		put(32'h510, 8'h20, 8'h00, 32'h1600, 32'h2600, 16'h0005);
		fire(8'h08);
		`CHK("repeat chain", 32'h1600 ^ pat, mm.ram[32'h2600])
		`CHK("reload", 8'h02, mm.ram[32'h50C][23:16])
	endtask
	task automatic t_short();
		wr(`TC_CTRL_OFS, 32'h400);
		mm.ram[32'h110] = 32'h600;
		mm.ram[32'h600] = 32'h2000_1700;
		mm.ram[32'h604] = 32'h0000_2700;
		mm.ram[32'h608] = 32'h0005_0000;
		mm.ram[32'hFF00_1700] = 32'h1234_5678;
		fire(8'h10);
		`CHK("short reads", 5, mm.n_rd)
		`CHK("short dest", 32'h1234_5678, mm.ram[32'hFF00_2700])
		`CHK("source", 8'h04, evt_src_o)
		wr(`TC_CTRL_OFS, 32'h0);
	endtask
	task automatic t_burst();
		mm.ram[32'h114] = 32'h700;
		mm.ram[32'h118] = 32'h710;
		put(32'h700, 8'h20, 8'h00, 32'h1800, 32'h2800, 16'h0005);
		put(32'h710, 8'h20, 8'h00, 32'h1900, 32'h2900, 16'h0005);
		fire(8'h60);
		`CHK("bus per source", 2, n_rise)
		wr(`TC_CTRL_OFS, 32'h800);
		mm.ram[32'h2800] = 32'h0;
		mm.ram[32'h2900] = 32'h0;
		fire(8'h60);
		`CHK("bus kept", 1, n_rise)
		`CHK("first served", 32'h1800 ^ pat, mm.ram[32'h2800])
		`CHK("both served", 32'h1900 ^ pat, mm.ram[32'h2900])
	endtask
	initial begin
		repeat (2) @(posedge mclk_i);
		reset_i <= 1'b0;
		@(posedge mclk_i);
		t_regs();
		wr(`TC_VBASE_OFS, 32'h100);
		wr(`TC_MASK_OFS, 32'h7);
		wr(`TC_ACTEN_OFS, 32'h7F);
		t_single();
		t_chain();
		t_zero();
		t_rep();
		t_short();
		t_burst();
		end_sim();
	end
endmodule
